/* File: smem_pkg.sv */
// Purpose: shared types and constants of the static memory pin interface
// Assumes: one clock, synchronous reset
// Notes: all setup, pulse and cycle fields are counts of clock cycles
package smem_pkg;

  localparam int NUM_CS = 8;
  localparam int CS_W = 3;
  localparam int ADDR_W = 26;
  localparam int DATA_W = 32;
  localparam int SET_W = 6;
  localparam int PUL_W = 7;
  localparam int CNT_W = 9;

  localparam logic [1:0] DBW_8 = 2'h0;
  localparam logic [1:0] DBW_16 = 2'h1;
  localparam logic [1:0] DBW_32 = 2'h2;
  localparam logic BAT_SELECT = 1'b0;
  localparam logic BAT_WRITE = 1'b1;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // fixed waveform used in slow clock mode
  localparam logic [SET_W-1:0] SLOW_SETUP = 6'h01;
  localparam logic [PUL_W-1:0] SLOW_PULSE = 7'h01;
  localparam logic [CNT_W-1:0] SLOW_CYCLE = 9'h003;

  // page bits above the word offset: 4, 8, 16 or 32 bytes
  localparam int PAGE_LO = 2;
  localparam int PAGE_HI = 5;

  typedef struct packed {
    logic read_mode;
    logic page_mode;
    logic [1:0] page_size;
    logic byte_access_type;
    logic [1:0] bus_width_sel;
    logic [SET_W-1:0] rd_setup;
    logic [PUL_W-1:0] rd_pulse;
    logic [SET_W-1:0] ncs_rd_setup;
    logic [PUL_W-1:0] ncs_rd_pulse;
    logic [CNT_W-1:0] rd_cycle;
    logic [SET_W-1:0] wr_setup;
    logic [PUL_W-1:0] wr_pulse;
    logic [SET_W-1:0] ncs_wr_setup;
    logic [PUL_W-1:0] ncs_wr_pulse;
    logic [CNT_W-1:0] wr_cycle;
  } smem_mode_type;

  typedef struct packed {
    logic [SET_W-1:0] stb_setup;
    logic [PUL_W-1:0] stb_pulse;
    logic [SET_W-1:0] ncs_setup;
    logic [PUL_W-1:0] ncs_pulse;
    logic [CNT_W-1:0] cycle;
  } smem_tim_type;

  typedef struct packed {
    logic write;
    logic [CS_W-1:0] cs;
    logic [ADDR_W-1:0] addr;
    logic [1:0] size;
    logic [DATA_W-1:0] wdata;
  } smem_req_type;

  // boot value: byte select, 16-bit, read on strobe, slow waveform
  localparam smem_mode_type BOOT_MODE = '{
    read_mode: 1'b1, page_mode: 1'b0, page_size: 2'h0,
    byte_access_type: BAT_SELECT, bus_width_sel: DBW_16,
    rd_setup: 6'h01, rd_pulse: 7'h10, ncs_rd_setup: 6'h00,
    ncs_rd_pulse: 7'h12, rd_cycle: 9'h012,
    wr_setup: 6'h01, wr_pulse: 7'h10, ncs_wr_setup: 6'h00,
    ncs_wr_pulse: 7'h12, wr_cycle: 9'h012};

endpackage

/* File: smem_phase.sv */
// Purpose: decodes one setup/pulse window from the access counter
// Assumes: pulse of at least one cycle
// Notes: last marks the cycle whose closing edge ends the pulse
`timescale 1ns/1ps
module smem_phase
  import smem_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input wire logic [CW-1:0] cnt_i,
  input wire logic [SET_W-1:0] setup_i,
  input wire logic [PUL_W-1:0] pulse_i,
  output logic active_o,
  output logic last_o
);

  initial begin
    if (CW < PUL_W + 1) begin
      $error("smem_phase: counter too narrow");
    end
  end

  logic [CW:0] start_w;
  logic [CW:0] stop_w;
  logic [CW:0] cnt_w;

  assign cnt_w = {1'b0, cnt_i};
  assign start_w = (CW+1)'(setup_i);
  assign stop_w = start_w + (CW+1)'(pulse_i);
  assign active_o = (cnt_w >= start_w) && (cnt_w < stop_w);
  assign last_o = (cnt_w == stop_w - (CW+1)'(1));

endmodule

/* File: smem_ctrl.sv */
// Purpose: pin front end of the static memory controller
// Assumes: pins synchronous to sys_clk_i; one access at a time
// Notes: per chip select modes are held here and loaded over a write port
// Behaviour
// - eight active-low chip selects and a 26-bit address bus
// - each chip select has its own 8, 16 or 32 bit width
// - each chip select decodes a 64 megabyte window
// - full address always driven so small devices repeat
// - significant address bits shrink with device width
// - 16/32-bit chip selects choose byte write or lane select access
// - byte write: one write strobe per lane, one shared read strobe
// - 32-bit byte write strobes 0..3 map to lanes 0..3
// - byte select: lane selects plus one read and one write strobe
// - lane selects 0..3 on 32-bit, only 0 and 1 on 16-bit
// - boot configuration uses byte select access
// - A0 unused on 16-bit, A0 and A1 unused on 32-bit
// - unused strobes or lane selects stay inactive
// - lane 0 pin: A0 on 8-bit, lane select 0 in byte select
// - lane 2 pin: A1, lane select 2 or write strobe 2
// - separate active-low read and write strobes
// - low wait request input stretches the access
// - slow clock mode swaps in a fixed waveform
// - page mode reads within pages up to 32 bytes
// - chip select of the addressed window goes low
// - setup, pulse and cycle counted in clock cycles
// - read data sampled at end of strobe or of chip select
`timescale 1ns/1ps
module smem_ctrl
  import smem_pkg::*;
#(
  parameter int NCS = NUM_CS
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic mode_we_i,
  input wire logic [CS_W-1:0] mode_cs_i,
  input wire smem_mode_type mode_i,
  input wire logic slow_clock_i,
  input wire logic req_valid_i,
  input wire smem_req_type req_i,
  output logic req_ready_o,
  output logic done_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic [NCS-1:0] chip_select_n_o,
  output logic [ADDR_W-1:2] addr_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic lane0_select_n_o,
  output logic lane1_select_n_o,
  output logic lane2_select_n_o,
  output logic lane3_select_n_o,
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o,
  input wire logic wait_request_n_i
);

  initial begin
    if (NCS != 8) begin
      $error("smem_ctrl: chip select count must be 8");
    end
  end

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_ACCESS = 1'b1
  } smem_state_type;

  smem_state_type state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  smem_req_type cur_ff, nxt_cur;
  smem_tim_type tim_ff, nxt_tim;
  smem_mode_type mode_ff [NCS];
  smem_mode_type cur_mode, new_mode;
  logic [3:0] nxt_lanes;
  logic accept, wait_hold, done, sample;
  logic stb_act, stb_last, ncs_act, ncs_last;
  logic nstb_act, nncs_act;
  logic page_hit;
  logic page_vld_ff;
  logic [CS_W-1:0] page_cs_ff;
  logic [ADDR_W-1:PAGE_LO] page_addr_ff;
  logic [ADDR_W-1:PAGE_LO] page_mask;

  function automatic smem_tim_type pick_tim(smem_mode_type m, logic wr, logic slow);
    smem_tim_type t;
    logic [CNT_W-1:0] e1;
    logic [CNT_W-1:0] e2;
    t.stb_setup = wr ? m.wr_setup : m.rd_setup;
    t.stb_pulse = wr ? m.wr_pulse : m.rd_pulse;
    t.ncs_setup = wr ? m.ncs_wr_setup : m.ncs_rd_setup;
    t.ncs_pulse = wr ? m.ncs_wr_pulse : m.ncs_rd_pulse;
    t.cycle = wr ? m.wr_cycle : m.rd_cycle;
    if (slow) begin
      t.stb_setup = SLOW_SETUP;
      t.stb_pulse = SLOW_PULSE;
      t.ncs_setup = '0;
      t.ncs_pulse = PUL_W'(SLOW_CYCLE);
      t.cycle = SLOW_CYCLE;
    end
    if (t.stb_pulse == '0) begin
      t.stb_pulse = PUL_W'(1);
    end
    if (t.ncs_pulse == '0) begin
      t.ncs_pulse = PUL_W'(1);
    end
    // hold is whatever is left of the cycle
    e1 = CNT_W'(t.stb_setup) + CNT_W'(t.stb_pulse);
    e2 = CNT_W'(t.ncs_setup) + CNT_W'(t.ncs_pulse);
    if (t.cycle < e1) begin
      t.cycle = e1;
    end
    if (t.cycle < e2) begin
      t.cycle = e2;
    end
    return t;
  endfunction

  // lanes touched by a transfer on the given width
  function automatic logic [3:0] lane_en(logic [1:0] bus_width_sel, logic wr, logic [1:0] sz, logic [1:0] a);
    logic [3:0] l;
    l = 4'h1;
    if (bus_width_sel == DBW_32) begin
      l = 4'hF;
      if (wr && sz == SIZE_BYTE) begin
        l = 4'(4'h1 << a);
      end else if (wr && sz == SIZE_HALF) begin
        l = a[1] ? 4'hC : 4'h3;
      end
    end else if (bus_width_sel == DBW_16) begin
      l = 4'h3;
      if (wr && sz == SIZE_BYTE) begin
        l = a[0] ? 4'h2 : 4'h1;
      end
    end
    return l;
  endfunction

  // write data moved down to the lanes of a narrow device
  function automatic logic [DATA_W-1:0] steer_wr(logic [1:0] bus_width_sel, logic [1:0] a, logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] o;
    o = d;
    if (bus_width_sel == DBW_8) begin
      o = d >> {a, 3'h0};
    end else if (bus_width_sel == DBW_16) begin
      o = d >> {a[1], 4'h0};
    end
    return o;
  endfunction

  function automatic logic [DATA_W-1:0] steer_rd(logic [1:0] bus_width_sel, logic [1:0] a, logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] o;
    o = d;
    if (bus_width_sel == DBW_8) begin
      o = {4{d[7:0]}};
    end else if (bus_width_sel == DBW_16) begin
      o = {2{d[15:0]}};
    end
    return o;
  endfunction

  assign cur_mode = mode_ff[cur_ff.cs];
  assign new_mode = mode_ff[req_i.cs];
  assign accept = req_valid_i && req_ready_o;

  smem_phase u_stb_cur (
    .cnt_i(cnt_ff),
    .setup_i(tim_ff.stb_setup),
    .pulse_i(tim_ff.stb_pulse),
    .active_o(stb_act),
    .last_o(stb_last)
  );

  smem_phase u_ncs_cur (
    .cnt_i(cnt_ff),
    .setup_i(tim_ff.ncs_setup),
    .pulse_i(tim_ff.ncs_pulse),
    .active_o(ncs_act),
    .last_o(ncs_last)
  );

  smem_phase u_stb_nxt (
    .cnt_i(nxt_cnt),
    .setup_i(nxt_tim.stb_setup),
    .pulse_i(nxt_tim.stb_pulse),
    .active_o(nstb_act),
    .last_o()
  );

  smem_phase u_ncs_nxt (
    .cnt_i(nxt_cnt),
    .setup_i(nxt_tim.ncs_setup),
    .pulse_i(nxt_tim.ncs_pulse),
    .active_o(nncs_act),
    .last_o()
  );

  // the device holds the access while it pulls wait low during the strobe or chip select pulse
  assign wait_hold = (state_ff == ST_ACCESS) && (stb_act || ncs_act) && !wait_request_n_i;
  assign done = (state_ff == ST_ACCESS) && !wait_hold && (cnt_ff == tim_ff.cycle - CNT_W'(1));
  // sample point chosen per chip select
  assign sample = (state_ff == ST_ACCESS) && !cur_ff.write && !wait_hold &&
                  (cur_mode.read_mode ? stb_last : ncs_last);

  // page hit on a read in the same page of the same chip select
  always_comb begin
    page_mask = '1;
    for (int i = PAGE_LO; i < PAGE_HI; i++) begin
      if (i - PAGE_LO < int'(new_mode.page_size)) begin
        page_mask[i] = 1'b0;
      end
    end
  end
  assign page_hit = new_mode.page_mode && !req_i.write && page_vld_ff && (page_cs_ff == req_i.cs) &&
                    (((page_addr_ff ^ req_i.addr[ADDR_W-1:PAGE_LO]) & page_mask) == '0);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_cur = cur_ff;
    nxt_tim = tim_ff;
    if (accept) begin
      nxt_state = ST_ACCESS;
      nxt_cur = req_i;
      nxt_tim = pick_tim(new_mode, req_i.write, slow_clock_i);
      // page hits skip the address setup phase
      nxt_cnt = page_hit ? CNT_W'(nxt_tim.stb_setup) : '0;
    end else if (state_ff == ST_ACCESS) begin
      if (done) begin
        nxt_state = ST_IDLE;
        nxt_cnt = '0;
      end else if (!wait_hold) begin
        nxt_cnt = cnt_ff + CNT_W'(1);
      end
    end
  end

  assign nxt_lanes = lane_en(mode_ff[nxt_cur.cs].bus_width_sel, nxt_cur.write, nxt_cur.size, nxt_cur.addr[1:0]);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      cur_ff <= '0;
      tim_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      cur_ff <= nxt_cur;
      tim_ff <= nxt_tim;
    end
  end

  // mode storage, reset to the boot setting
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NCS; i++) begin
        mode_ff[i] <= BOOT_MODE;
      end
    end else if (mode_we_i) begin
      mode_ff[mode_cs_i] <= mode_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      page_vld_ff <= 1'b0;
      page_cs_ff <= '0;
      page_addr_ff <= '0;
    end else if (accept) begin
      page_vld_ff <= !req_i.write;
      page_cs_ff <= req_i.cs;
      page_addr_ff <= req_i.addr[ADDR_W-1:PAGE_LO];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      req_ready_o <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= '0;
    end else begin
      req_ready_o <= (nxt_state == ST_IDLE);
      done_o <= done;
      if (sample) begin
        rdata_o <= steer_rd(cur_mode.bus_width_sel, cur_ff.addr[1:0], data_i);
      end
    end
  end

  // chip select of the addressed window, full address on the bus
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      chip_select_n_o <= '1;
      addr_o <= '0;
    end else begin
      chip_select_n_o <= ~(NCS'(nxt_state == ST_ACCESS && nncs_act) << nxt_cur.cs);
      addr_o <= nxt_cur.addr[ADDR_W-1:2];
    end
  end

  // shared strobe and lane pins
  always_ff @(posedge sys_clk_i) begin
    logic on, wstb;
    logic [1:0] bus_width_sel;
    logic byte_access_type;
    on = 1'b0;
    wstb = 1'b0;
    bus_width_sel = '0;
    byte_access_type = 1'b0;
    if (rst_i) begin
      read_strobe_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      lane0_select_n_o <= 1'b1;
      lane1_select_n_o <= 1'b1;
      lane2_select_n_o <= 1'b1;
      lane3_select_n_o <= 1'b1;
    end else begin
      on = (nxt_state == ST_ACCESS);
      wstb = on && nstb_act && nxt_cur.write;
      bus_width_sel = mode_ff[nxt_cur.cs].bus_width_sel;
      byte_access_type = mode_ff[nxt_cur.cs].byte_access_type;
      read_strobe_n_o <= !(on && nstb_act && !nxt_cur.write);
      if (!on) begin
        write_strobe_n_o <= 1'b1;
        lane0_select_n_o <= 1'b1;
        lane1_select_n_o <= 1'b1;
        lane2_select_n_o <= 1'b1;
        lane3_select_n_o <= 1'b1;
      end else if (bus_width_sel == DBW_8) begin
        write_strobe_n_o <= !wstb;
        lane0_select_n_o <= nxt_cur.addr[0];
        lane1_select_n_o <= 1'b1;
        lane2_select_n_o <= nxt_cur.addr[1];
        lane3_select_n_o <= 1'b1;
      end else if (byte_access_type == BAT_SELECT) begin
        write_strobe_n_o <= !wstb;
        lane0_select_n_o <= !nxt_lanes[0];
        lane1_select_n_o <= !nxt_lanes[1];
        lane2_select_n_o <= (bus_width_sel == DBW_32) ? !nxt_lanes[2] : nxt_cur.addr[1];
        lane3_select_n_o <= (bus_width_sel == DBW_32) ? !nxt_lanes[3] : 1'b1;
      end else begin
        write_strobe_n_o <= !(wstb && nxt_lanes[0]);
        lane0_select_n_o <= 1'b1;
        lane1_select_n_o <= !(wstb && nxt_lanes[1]);
        lane2_select_n_o <= (bus_width_sel == DBW_32) ? !(wstb && nxt_lanes[2]) : nxt_cur.addr[1];
        lane3_select_n_o <= (bus_width_sel == DBW_32) ? !(wstb && nxt_lanes[3]) : 1'b1;
      end
    end
  end

  // data driven for the whole write access
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      data_o <= '0;
      data_oe_o <= 1'b0;
    end else begin
      data_o <= steer_wr(mode_ff[nxt_cur.cs].bus_width_sel, nxt_cur.addr[1:0], nxt_cur.wdata);
      data_oe_o <= (nxt_state == ST_ACCESS) && nxt_cur.write;
    end
  end

endmodule

/* File: smem_ctrl_monitor.sv */
// Purpose: port checker for smem_ctrl
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every smem_ctrl instance
`timescale 1ns/1ps
module smem_ctrl_monitor
  import smem_pkg::*;
#(
  parameter int NCS = NUM_CS
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic done_o,
  input wire logic [NCS-1:0] chip_select_n_o,
  input wire logic [ADDR_W-1:2] addr_o,
  input wire logic read_strobe_n_o,
  input wire logic write_strobe_n_o,
  input wire logic data_oe_o,
  input wire logic wait_request_n_i
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  property p_onehot; $countones(~chip_select_n_o) <= 1; endproperty
  a_onehot: assert property (p_onehot) else $error("two chip selects low");
  property p_excl; !(!read_strobe_n_o && !write_strobe_n_o); endproperty
  a_excl: assert property (p_excl) else $error("read and write strobe low together");
  property p_idle; req_ready_o |-> (read_strobe_n_o && write_strobe_n_o && !data_oe_o); endproperty
  a_idle: assert property (p_idle) else $error("strobe active while idle");
  property p_oe; data_oe_o |-> read_strobe_n_o; endproperty
  a_oe: assert property (p_oe) else $error("data driven during read strobe");
  property p_take; (req_valid_i && req_ready_o) |=> (!req_ready_o && !done_o); endproperty
  a_take: assert property (p_take) else $error("accepted request did not start");
  property p_done; done_o |-> req_ready_o ##1 !done_o; endproperty
  a_done: assert property (p_done) else $error("done not a single idle pulse");
  property p_wait; (!wait_request_n_i && !read_strobe_n_o && !req_ready_o) |=> (!read_strobe_n_o && !done_o);
  endproperty
  a_wait: assert property (p_wait) else $error("wait request did not stretch read");
  property p_addr; (!req_ready_o && !$past(req_ready_o)) |-> $stable(addr_o); endproperty
  a_addr: assert property (p_addr) else $error("address moved inside access");
endmodule

bind smem_ctrl smem_ctrl_monitor #(.NCS(NCS)) i_mon (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .done_o(done_o), .chip_select_n_o(chip_select_n_o),
  .addr_o(addr_o), .read_strobe_n_o(read_strobe_n_o), .write_strobe_n_o(write_strobe_n_o),
  .data_oe_o(data_oe_o), .wait_request_n_i(wait_request_n_i));

/* File: smem_sram_model.sv */
// Purpose: 32-bit byte select static memory on chip select 1
// Assumes: sixteen words, image repeats across the window
// Notes: released bus shows a changing pattern
`timescale 1ns/1ps
module smem_sram_model
  import smem_pkg::*;
#(
  parameter int NCS = NUM_CS,
  parameter int STALL = 3
) (
  input wire logic sys_clk_i,
  input wire logic stall_en_i,
  input wire logic [NCS-1:0] chip_select_n_i,
  input wire logic [ADDR_W-1:2] addr_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic [3:0] lane_n_i,
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] data_o,
  output logic wait_request_n_o
);
  logic [DATA_W-1:0] mem [0:15];
  logic [DATA_W-1:0] last_q = '0;
  logic did_q = 1'b0;
  int hold_q = 0;
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = '0;
    end
  end
  assign data_o = (!chip_select_n_i[1] && !read_strobe_n_i) ? mem[addr_i[5:2]] : ~last_q;
  assign wait_request_n_o = (hold_q == 0);
  always @(posedge sys_clk_i) begin
    last_q <= data_o;
    if (!chip_select_n_i[1] && !write_strobe_n_i) begin
      for (int b = 0; b < 4; b++) begin
        if (!lane_n_i[b]) begin
          mem[addr_i[5:2]][8*b +: 8] <= data_i[8*b +: 8];
        end
      end
    end
    if (!stall_en_i) begin
      did_q <= 1'b0;
    end else if (!read_strobe_n_i && !did_q) begin
      hold_q <= STALL;
      did_q <= 1'b1;
    end else if (hold_q > 0) begin
      hold_q <= hold_q - 1;
    end
  end
endmodule

/* File: smem_ctrl_tb.sv */
// Purpose: self-checking bench for smem_ctrl
// Assumes: 125 MHz clock, reset held 16 cycles
// Notes: pin activity is collected over each access
`timescale 1ns/1ps
module smem_ctrl_tb
  import smem_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic mode_we = 1'b0;
  logic [CS_W-1:0] mode_cs = '0;
  smem_mode_type mode = BOOT_MODE;
  logic slow = 1'b0;
  logic req_valid = 1'b0;
  logic stall = 1'b0;
  smem_req_type req = '0;
  logic req_ready, done, oe, rd_n, wr_n, wait_n, rd_seen, wr_seen, oe_seen;
  logic [3:0] lane_n, ln_seen;
  logic [7:0] cs_n, cs_seen;
  logic [ADDR_W-1:2] addr;
  logic [DATA_W-1:0] rdata, dout, din;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int dur;
  always #4 sys_clk = ~sys_clk;
  smem_ctrl i_dut (.sys_clk_i(sys_clk), .rst_i(rst), .mode_we_i(mode_we), .mode_cs_i(mode_cs), .mode_i(mode),
    .slow_clock_i(slow), .req_valid_i(req_valid), .req_i(req), .req_ready_o(req_ready), .done_o(done),
    .rdata_o(rdata), .chip_select_n_o(cs_n), .addr_o(addr), .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n),
    .lane0_select_n_o(lane_n[0]), .lane1_select_n_o(lane_n[1]), .lane2_select_n_o(lane_n[2]),
    .lane3_select_n_o(lane_n[3]), .data_i(din), .data_o(dout), .data_oe_o(oe), .wait_request_n_i(wait_n));
  smem_sram_model i_mem (.sys_clk_i(sys_clk), .stall_en_i(stall), .chip_select_n_i(cs_n), .addr_i(addr),
    .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .lane_n_i(lane_n), .data_i(dout), .data_o(din),
    .wait_request_n_o(wait_n));
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic smem_mode_type mk(input logic b, input logic [1:0] w, input logic pg);
    smem_mode_type m;
    m = BOOT_MODE;
    m.byte_access_type = b;
    m.bus_width_sel = w;
    m.page_mode = pg;
    m.page_size = 2'h3;
    m.rd_pulse = 7'h02;
    m.ncs_rd_pulse = 7'h04;
    m.rd_cycle = 9'h004;
    m.wr_pulse = 7'h02;
    m.ncs_wr_pulse = 7'h04;
    m.wr_cycle = 9'h004;
    return m;
  endfunction
  task automatic setm(input logic [2:0] c, input smem_mode_type m);
    @(posedge sys_clk);
    mode_we <= 1'b1;
    mode_cs <= c;
    mode <= m;
    @(posedge sys_clk);
    mode_we <= 1'b0;
  endtask
  // one access; collects which pins went low and counts edges to done
  task automatic acc(input logic w, input logic [2:0] c, input logic [25:0] a, input logic [1:0] s,
                     input logic [31:0] d);
    int n;
    n = 0;
    cs_seen = '0;
    ln_seen = '0;
    rd_seen = 1'b0;
    wr_seen = 1'b0;
    oe_seen = 1'b0;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req <= '{write: w, cs: c, addr: a, size: s, wdata: d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    req_valid <= 1'b0;
    n = 0;
    do begin
      #1;
      cs_seen |= ~cs_n;
      ln_seen |= ~lane_n;
      rd_seen |= ~rd_n;
      wr_seen |= ~wr_n;
      oe_seen |= oe;
      @(posedge sys_clk);
      n++;
    end while (done !== 1'b1 && n < 400);
    dur = n;
    if (done !== 1'b1) begin
      bad_count++;
    end
  endtask
  initial begin
    smem_mode_type m;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk({req_ready, cs_n, rd_n, wr_n, lane_n, oe}, {1'b1, 8'hFF, 6'h3F, 1'b0});
    acc(1'b1, 3'h0, 26'h0000002, SIZE_HALF, 32'h12345678);
    chk(cs_seen, 8'h01);
    chk({oe_seen, rd_seen, wr_seen, ln_seen}, 7'h53);
    chk(dur, 19);
    $display("boot test done");
    setm(3'h1, mk(BAT_SELECT, DBW_32, 1'b0));
    acc(1'b1, 3'h1, 26'h0000010, SIZE_WORD, 32'h11223344);
    chk({cs_seen, ln_seen}, 12'h02F);
    chk(dur, 5);
    acc(1'b1, 3'h1, 26'h0000013, SIZE_BYTE, 32'hAAAAAAAA);
    chk(ln_seen, 4'h8);
    acc(1'b0, 3'h1, 26'h3FFFF10, SIZE_WORD, 32'h0);
    chk(rdata, 32'hAA223344);
    chk({addr, ln_seen}, {24'hFFFFC4, 4'hF});
    $display("byte select test done");
    stall <= 1'b1;
    acc(1'b0, 3'h1, 26'h0000010, SIZE_WORD, 32'h0);
    chk(dur, 8);
    chk(rdata, 32'hAA223344);
    stall <= 1'b0;
    $display("wait test done");
    setm(3'h1, mk(BAT_SELECT, DBW_32, 1'b1));
    acc(1'b0, 3'h1, 26'h0000010, SIZE_WORD, 32'h0);
    acc(1'b0, 3'h1, 26'h0000014, SIZE_WORD, 32'h0);
    chk(dur, 4);
    acc(1'b0, 3'h1, 26'h000001C, SIZE_WORD, 32'h0);
    chk(dur, 4);
    acc(1'b0, 3'h1, 26'h0000050, SIZE_WORD, 32'h0);
    chk(dur, 5);
    $display("page test done");
    setm(3'h2, mk(BAT_WRITE, DBW_32, 1'b0));
    acc(1'b1, 3'h2, 26'h0000002, SIZE_HALF, 32'h55667788);
    chk({wr_seen, ln_seen}, 5'h0C);
    acc(1'b1, 3'h2, 26'h0000000, SIZE_BYTE, 32'h99999999);
    chk({wr_seen, ln_seen}, 5'h10);
    acc(1'b0, 3'h2, 26'h0000000, SIZE_WORD, 32'h0);
    chk({oe_seen, rd_seen, wr_seen, ln_seen}, 7'h20);
    setm(3'h4, mk(BAT_WRITE, DBW_16, 1'b0));
    acc(1'b1, 3'h4, 26'h0000000, SIZE_HALF, 32'h0000BEEF);
    chk({wr_seen, ln_seen}, 5'h16);
    $display("byte write test done");
    setm(3'h3, mk(BAT_SELECT, DBW_8, 1'b0));
    acc(1'b0, 3'h3, 26'h0000003, SIZE_BYTE, 32'h0);
    chk(ln_seen, 4'h0);
    acc(1'b1, 3'h3, 26'h0000000, SIZE_BYTE, 32'h000000C3);
    chk({wr_seen, ln_seen}, 5'h15);
    $display("narrow bus test done");
    m = mk(BAT_SELECT, DBW_32, 1'b0);
    m.read_mode = 1'b0;
    m.ncs_rd_pulse = 7'h02;
    setm(3'h1, m);
    acc(1'b0, 3'h1, 26'h0000010, SIZE_WORD, 32'h0);
    chk(rdata, 32'hAA223344);
    $display("read mode test done");
    slow <= 1'b1;
    acc(1'b0, 3'h5, 26'h0000040, SIZE_HALF, 32'h0);
    chk({cs_seen, 8'(dur)}, {8'h20, 8'(SLOW_CYCLE) + 8'h01});
    slow <= 1'b0;
    $display("slow clock test done");
    close_out();
  end
endmodule
